// ---- inc/aeis_pkg.sv ----
// Package with register map, widths and reset values of the early interrupt status bank
package aeis_pkg;
    // ==========================================================
    // Geometry
    localparam int NUM_INPUTS = 22;
    localparam int REG_WIDTH = 16;
    localparam int HIGH_BITS = 6;
    // ==========================================================
    // Register byte offsets
    localparam logic [11:0] OFS_STATUS_LOW = 12'h000;
    localparam logic [11:0] OFS_STATUS_HIGH = 12'h004;
    // ==========================================================
    // Field layout and reset values
    localparam int LOW_FIRST_INPUT = 0;
    localparam int HIGH_FIRST_INPUT = 16;
    localparam logic [15:0] RST_STATUS_LOW = 16'h0000;
    localparam logic [15:0] RST_STATUS_HIGH = 16'h0000;
    localparam logic [15:0] HIGH_IMPL_MASK = 16'h003F;
    // ==========================================================
    // AHB encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ = 2'h3;
endpackage

// ---- rtl/aeis_flag.sv ----
// One early interrupt flag with event set, buffer read clear and software write
`timescale 1ns/100ps
module aeis_flag (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic early_irq_event,
    input wire logic buffer_read,
    input wire logic sw_write,
    input wire logic sw_data,
    output logic early_irq_flag
);
    typedef struct packed {
        logic flag;
    } aeis_flag_state_t;

    aeis_flag_state_t state;
    aeis_flag_state_t next_state;

    // ==========================================================
    // Next flag value: event beats clear and write
    always_comb begin
        next_state = state;
        if (sw_write) begin
            next_state.flag = sw_data;
        end
        if (buffer_read) begin
            next_state.flag = 1'b0;
        end
        if (early_irq_event) begin
            next_state.flag = 1'b1;
        end
    end

    // Flag register, zero at reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign early_irq_flag = state.flag;

    // ==========================================================
    // Checks
    event_sets_a: assert property (@(posedge hclk) disable iff (!hresetn)
        early_irq_event |=> early_irq_flag)
        else $error("flag not set after event");
    read_clears_a: assert property (@(posedge hclk) disable iff (!hresetn)
        buffer_read && !early_irq_event && !sw_write |=> !early_irq_flag)
        else $error("flag not cleared by buffer read");
    set_wins_a: assert property (@(posedge hclk) disable iff (!hresetn)
        early_irq_event && buffer_read |=> early_irq_flag)
        else $error("event lost against buffer read");
    flag_holds_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !early_irq_event && !buffer_read && !sw_write |=> $stable(early_irq_flag))
        else $error("flag changed without cause");
endmodule

// ---- rtl/aeis_status_bank.sv ----
// AHB-Lite slave holding the 22 early interrupt status flags of the converter
// Operation
// - Each analog input has a flag that is set when its early interrupt fires.
// - Reading an input's conversion result buffer clears that input's flag.
// - Low register holds inputs 0..15 in bits 15..0, high holds inputs 16..21 in bits 5..0.
// - High register bits 15..6 read as zero and ignore writes.
// - All implemented flags are software readable and writable and reset to zero.
//
// Our own choices: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/100ps
module aeis_status_bank (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [21:0] early_irq_event,
    input wire logic [21:0] conversion_result_buffer_read,
    output logic [21:0] early_irq_flag
);
    typedef struct packed {
        logic wr_pend;
        logic [11:0] wr_addr;
        logic [31:0] rdata;
        logic [21:0] flag_out;
    } aeis_bank_state_t;

    aeis_bank_state_t state;
    aeis_bank_state_t next_state;
    logic [21:0] flags;
    logic [21:0] sw_write;
    logic [21:0] sw_data;
    logic addr_phase;

    // ==========================================================
    // Register selection
    function automatic logic is_reg(input logic [11:0] a, input logic [11:0] ofs);
        return a == ofs;
    endfunction

    // Low register word: inputs 0..15 in bits 15..0
    function automatic logic [31:0] low_word(input logic [21:0] f);
        return {16'h0000, f[15:0]};
    endfunction

    // High register word: inputs 16..21 in bits 5..0, upper bits forced to zero
    function automatic logic [31:0] high_word(input logic [21:0] f);
        logic [15:0] h;
        h = {10'h000, f[21:16]} & aeis_pkg::HIGH_IMPL_MASK;
        return {16'h0000, h};
    endfunction

    // Read value of a register offset; unmapped offsets read zero
    function automatic logic [31:0] read_value(input logic [11:0] a, input logic [21:0] f);
        logic [31:0] v;
        v = 32'h00000000;
        if (is_reg(a, aeis_pkg::OFS_STATUS_LOW)) begin
            v = low_word(f);
        end else if (is_reg(a, aeis_pkg::OFS_STATUS_HIGH)) begin
            v = high_word(f);
        end
        return v;
    endfunction

    // Address phase qualifier; htrans bit 1 marks NONSEQ and SEQ alike

    assign addr_phase = hsel && hready && htrans[1];

    // ==========================================================
    // Write decode of the pending data phase
    always_comb begin
        sw_write = '0;
        sw_data = '0;
        if (state.wr_pend && is_reg(state.wr_addr, aeis_pkg::OFS_STATUS_LOW)) begin
            sw_write[15:0] = 16'hFFFF;
            sw_data[15:0] = hwdata[15:0];
        end
        if (state.wr_pend && is_reg(state.wr_addr, aeis_pkg::OFS_STATUS_HIGH)) begin
            sw_write[21:16] = 6'h3F; // upper bits have no storage
            sw_data[21:16] = hwdata[5:0];
        end
    end

    // ==========================================================
    // One flag cell per analog input
    generate
        for (genvar i = 0; i < aeis_pkg::NUM_INPUTS; i++) begin : g_flag
            aeis_flag u_flag (
                .hclk(hclk),
                .hresetn(hresetn),
                .early_irq_event(early_irq_event[i]),
                .buffer_read(conversion_result_buffer_read[i]),
                .sw_write(sw_write[i]),
                .sw_data(sw_data[i]),
                .early_irq_flag(flags[i])
            );
        end
    endgenerate

    // ==========================================================
    // Bus phase tracking and read data capture
    always_comb begin
        next_state = state;
        next_state.wr_pend = addr_phase && hwrite;
        next_state.wr_addr = haddr[11:0];
        next_state.flag_out = flags;
        if (addr_phase && !hwrite) begin
            next_state.rdata = read_value(haddr[11:0], flags);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    // Read data and flag output straight from flops; zero wait, always OKAY
    assign hrdata = state.rdata;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign early_irq_flag = state.flag_out;

    // ==========================================================
    // Checks
    high_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
        addr_phase && !hwrite && haddr[11:0] == aeis_pkg::OFS_STATUS_HIGH
        |=> hrdata[31:6] == 26'h0)
        else $error("high register upper bits not zero");
    low_read_a: assert property (@(posedge hclk) disable iff (!hresetn)
        addr_phase && !hwrite && haddr[11:0] == aeis_pkg::OFS_STATUS_LOW
        |=> hrdata[15:0] == $past(flags[15:0]))
        else $error("low register read mismatch");
    high_read_a: assert property (@(posedge hclk) disable iff (!hresetn)
        addr_phase && !hwrite && haddr[11:0] == aeis_pkg::OFS_STATUS_HIGH
        |=> hrdata[5:0] == $past(flags[21:16]))
        else $error("high register read mismatch");
    sw_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
        state.wr_pend && state.wr_addr == aeis_pkg::OFS_STATUS_LOW
        && early_irq_event[15:0] == 16'h0000 && conversion_result_buffer_read[15:0] == 16'h0000
        |=> flags[15:0] == $past(hwdata[15:0]))
        else $error("software write not stored");
    flag_mirror_a: assert property (@(posedge hclk) disable iff (!hresetn)
        early_irq_event != 22'h0 |=> ##1 (early_irq_flag & $past(early_irq_event, 2))
        == $past(early_irq_event, 2))
        else $error("flag output missing event");

    // Unmapped offsets return an all-zero word
    unmapped_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
        addr_phase && !hwrite && !is_reg(haddr[11:0], aeis_pkg::OFS_STATUS_LOW)
        && !is_reg(haddr[11:0], aeis_pkg::OFS_STATUS_HIGH)
        |=> hrdata == 32'h00000000)
        else $error("unmapped read not zero");

    // High register write lands in the six implemented flags only
    high_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
        state.wr_pend && state.wr_addr == aeis_pkg::OFS_STATUS_HIGH
        && early_irq_event[21:16] == 6'h00 && conversion_result_buffer_read[21:16] == 6'h00
        |=> flags[21:16] == $past(hwdata[5:0]))
        else $error("high register write not stored");

    // Flag output is the internal flag one cycle later
    flag_copy_a: assert property (@(posedge hclk) disable iff (!hresetn)
        1'b1 |=> early_irq_flag == $past(flags))
        else $error("flag output not a copy of the flags");

    // First edge after reset release sees cleared flags and read data
    reset_clear_a: assert property (@(posedge hclk)
        $rose(hresetn) |-> flags == 22'h000000 && hrdata == 32'h00000000)
        else $error("state not cleared by reset");

    // Per-input checks of clear and collision priority
    generate
        for (genvar j = 0; j < aeis_pkg::NUM_INPUTS; j++) begin : g_chk
            // A set on the same edge as a buffer read survives
            collide_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
                early_irq_event[j] && conversion_result_buffer_read[j] |=> flags[j])
                else $error("collision lost an event");
            // A lone buffer read clears its flag
            clear_bank_a: assert property (@(posedge hclk) disable iff (!hresetn)
                conversion_result_buffer_read[j] && !early_irq_event[j] && !sw_write[j]
                |=> !flags[j])
                else $error("buffer read left a flag set");
        end
    endgenerate

    write_low_c: cover property (@(posedge hclk) disable iff (!hresetn)
        state.wr_pend && state.wr_addr == aeis_pkg::OFS_STATUS_LOW);
    read_high_c: cover property (@(posedge hclk) disable iff (!hresetn)
        addr_phase && !hwrite && haddr[11:0] == aeis_pkg::OFS_STATUS_HIGH);
    collide_c: cover property (@(posedge hclk) disable iff (!hresetn)
        (early_irq_event & conversion_result_buffer_read) != 22'h0);
    write_high_c: cover property (@(posedge hclk) disable iff (!hresetn)
        state.wr_pend && state.wr_addr == aeis_pkg::OFS_STATUS_HIGH);
    unmapped_read_c: cover property (@(posedge hclk) disable iff (!hresetn)
        addr_phase && !hwrite && !is_reg(haddr[11:0], aeis_pkg::OFS_STATUS_LOW)
        && !is_reg(haddr[11:0], aeis_pkg::OFS_STATUS_HIGH));
endmodule

// ---- dv/tb_top.sv ----
// Self-checking bench for the early interrupt status bank
`timescale 1ns/100ps
module tb_top;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic [21:0] ev = 22'h0;
    logic [21:0] clr = 22'h0;
    logic [21:0] flag;
    logic [21:0] model = 22'h0;
    logic [21:0] r;
    logic [31:0] exp_q[$];
    logic rd_dp = 1'b0;
    int errors = 0;
    int tests_run = 0;
    int cyc = 0;

    aeis_status_bank u_aeis_status_bank (
        .hclk(hclk),
        .hresetn(hresetn),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hwdata(hwdata),
        .hready(hreadyout),
        .hrdata(hrdata),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .early_irq_event(ev),
        .conversion_result_buffer_read(clr),
        .early_irq_flag(flag)
    );

    // ==========================================================
    // Clock, timeout and reporting
    always #10 hclk = ~hclk;

    always @(posedge hclk) begin
        cyc++;
        if (cyc == 5000) begin
            errors++;
            stop_test();
        end
    end

    task automatic stop_test;
        $display("Checks %0d, errors %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            errors++;
            $display("ERROR %s expected %h seen %h", name, e, g);
        end
    endtask

    // ==========================================================
    // Monitor: read data taken at the end of its data phase
    always @(posedge hclk) begin
        if (rd_dp && hreadyout === 1'b1) begin
            chk("hrdata", exp_q.pop_front(), hrdata);
            chk("hresp", 32'h0, {31'h0, hresp});
        end
        rd_dp <= hsel && htrans[1] && !hwrite && hreadyout === 1'b1;
    end

    // ==========================================================
    // Bus and event drivers
    task automatic bus(input logic [11:0] ofs, input logic wr, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {20'h0, ofs};
        htrans <= aeis_pkg::HTRANS_NONSEQ;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wr ? d : 32'h0;
        do @(posedge hclk); while (hreadyout !== 1'b1);
    endtask

    task automatic rd(input logic [11:0] ofs, input logic [31:0] e);
        exp_q.push_back(e);
        bus(ofs, 1'b0, 32'h0);
    endtask

    // Both registers plus the flag outputs against the model
    task automatic rd_all;
        rd(aeis_pkg::OFS_STATUS_LOW, {16'h0, model[15:0]});
        rd(aeis_pkg::OFS_STATUS_HIGH, {26'h0, model[21:16]});
        #1;
        chk("early_irq_flag", {10'h0, model}, {10'h0, flag});
    endtask

    // One-cycle event and buffer-read strobes; event wins
    task automatic pulse(input logic [21:0] e, input logic [21:0] c);
        @(posedge hclk);
        ev <= e;
        clr <= c;
        @(posedge hclk);
        ev <= 22'h0;
        clr <= 22'h0;
        model = (model & ~c) | e;
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        void'($urandom(32'h2bb9));
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        rd_all();
        rd(12'h008, 32'h0);
        for (int i = 0; i < 4; i++) begin
            r = 22'($urandom);
            pulse(r, 22'h0);
            rd_all();
            r = 22'($urandom);
            pulse(22'h0, r);
            rd_all();
            pulse(r, r);
            rd_all();
        end
        bus(aeis_pkg::OFS_STATUS_LOW, 1'b1, 32'hFFFFFFFF);
        bus(aeis_pkg::OFS_STATUS_HIGH, 1'b1, 32'hFFFFFFFF);
        model = 22'h3FFFFF;
        rd_all();
        bus(aeis_pkg::OFS_STATUS_LOW, 1'b1, 32'h0000A5A5);
        bus(aeis_pkg::OFS_STATUS_HIGH, 1'b1, 32'hFFFF002A);
        model = {6'h2A, 16'hA5A5};
        rd_all();
        // Mid-run reset clears every flag
        @(posedge hclk);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        model = 22'h0;
        rd_all();
        repeat (3) @(posedge hclk);
        stop_test();
    end
endmodule
